//--- rtl/cdbu_pkg.sv
// cdbu_pkg: register map, field positions and trap constants of the debug break unit
// assumes: registers sit in one alternate space reached by the core's load/store port
// Function
// - debug unit works only if enable pin was low at reset, else breaks off
// - only software breaks write trap type 255; every debug trap ignores the trap table base
// - debug trap vector is always 0x00000FF0, whatever the trap base register holds
// - debug traps run at priority 2, above everything except reset
// - debug traps may be taken while trap enable is zero, per control setting
// - with traps off and that control bit zero, only software breaks still occur
// - entry saves previous-supervisor and trap-enable; return writes them back
// - entry sets in-break-routine bit; return-from-trap while set clears it
// - break-active output is high while the break routine runs
// - in normal mode the debug unit stays idle to save power
// - in debug mode a low external break input raises a debug trap
// - external break held across reset release sends the core to the routine
// - two comparators trap on pc, privilege bit and enable all matching
// - single step traps after every executed instruction
// - trap-always with number 255 is a software break raising a debug trap
// - a 16-entry trace keeps fetched addresses while in debug mode, except while the break routine runs
// - status bits 15-12 point at the newest trace entry, address bits 5:2
// - status bit 6 flags external break; writing zero clears it
// - status bit 1 shows the enable level sampled at reset
// - status bits 3 and 2 are read/write match flags of comparators 1 and 2
package cdbu_pkg;
  localparam logic [7:0] DBG_ASI = 8'h01;
  localparam logic [31:0] OFS_BREAK_ADDR_1 = 32'h0000ff00;
  localparam logic [31:0] OFS_BREAK_ADDR_2 = 32'h0000ff04;
  localparam logic [31:0] OFS_CONTROL = 32'h0000ff18;
  localparam logic [31:0] OFS_STATUS = 32'h0000ff1c;
  localparam logic [31:0] OFS_TRACE_LO = 32'h0000ff40;
  localparam logic [31:0] OFS_TRACE_HI = 32'h0000ff7c;
  localparam logic [31:0] CONTROL_RESET = 32'h00000400;
  localparam logic [31:0] CONTROL_WR_MASK = 32'h0000e470;
  localparam logic [31:0] BREAK_ADDR_RESET = 32'h00000000;
  localparam logic [3:0] TRACE_PTR_RESET = 4'hf;
  localparam logic [7:0] TRAP_TYPE = 8'hff;
  localparam logic [31:0] TRAP_VECTOR = 32'h00000ff0;
  localparam logic [1:0] TRAP_LEVEL = 2'h2;
  localparam int CTL_PRIV_2 = 15;
  localparam int CTL_PRIV_1 = 14;
  localparam int CTL_SOFT_FLAG = 13;
  localparam int CTL_TRAPS_OFF = 10;
  localparam int CTL_IN_BREAK = 9;
  localparam int CTL_EN_2 = 6;
  localparam int CTL_EN_1 = 5;
  localparam int CTL_STEP = 4;
  localparam int ST_PTR_LSB = 12;
  localparam int ST_SAVED_PS = 9;
  localparam int ST_SAVED_ET = 8;
  localparam int ST_EXT_SEEN = 6;
  localparam int ST_MATCH_1 = 3;
  localparam int ST_MATCH_2 = 2;
  localparam int ST_MODE_N = 1;
  localparam int TRACE_DEPTH = 16;
endpackage

//--- rtl/cdbu_sync.sv
// cdbu_sync: two-flop synchroniser for one asynchronous pin
// assumes: the pin may change at any time relative to ref_clk
`timescale 1ns/10ps
module cdbu_sync
(
  input wire logic ref_clk, // core clock
  input wire logic pin_in, // asynchronous pin level
  output logic pin_sync // level after two flops
);
  logic stage_1;

  // no reset so the pin level is visible while reset is held
  always_ff @(posedge ref_clk)
  begin
    stage_1 <= pin_in;
    pin_sync <= stage_1;
  end
endmodule

//--- rtl/cdbu_trace.sv
// cdbu_trace: cyclic trace of fetched instruction addresses
// assumes: one write per clock at most; reads return word address bits 31:2
`timescale 1ns/10ps
module cdbu_trace
(
  input wire logic ref_clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic wr_en, // store one fetched address
  input wire logic [29:0] wr_addr, // fetched address bits 31:2
  input wire logic [3:0] rd_index, // entry to read
  output logic [29:0] rd_addr, // entry contents, combinational
  output logic [3:0] newest // entry holding the newest address
);
  logic [29:0] entries [cdbu_pkg::TRACE_DEPTH];

  // pointer advances then the new address lands on it, wrapping over the oldest
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      newest <= cdbu_pkg::TRACE_PTR_RESET;
    else if (wr_en)
      newest <= newest + 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
      entries[newest + 4'h1] <= wr_addr;
  end

  assign rd_addr = entries[rd_index];
endmodule

//--- rtl/cdbu_unit.sv
// cdbu_unit: debug break unit with comparators, step, software and external breaks
// assumes: the core takes trap_req at once and flags rett_exec on return-from-trap
`timescale 1ns/10ps
module cdbu_unit
(
  input wire logic ref_clk, // core clock, 200 MHz
  input wire logic reset, // synchronous, active high
  input wire logic debug_enable_n_pin, // low at reset selects debug mode
  input wire logic external_break_n, // asynchronous break request, low
  input wire logic reg_en, // register access strobe
  input wire logic reg_wr, // 1 write, 0 read
  input wire logic [7:0] reg_asi, // alternate space of the access
  input wire logic [31:0] reg_addr, // byte address of the access
  input wire logic [31:0] reg_wdata, // write data
  output logic [31:0] reg_rdata, // read data, one cycle after the strobe
  input wire logic pc_valid, // pc_exec holds an instruction about to execute
  input wire logic [31:0] pc_exec, // executing program counter
  input wire logic instr_done, // one instruction has completed
  input wire logic sw_break_instr, // trap-always 255 is executing
  input wire logic rett_exec, // return-from-trap is executing
  input wire logic psr_s, // supervisor bit
  input wire logic psr_ps, // previous-supervisor bit
  input wire logic psr_et, // trap enable bit
  input wire logic fetch_valid, // an instruction is fetched
  input wire logic [31:0] fetch_addr, // address of that fetch
  output logic trap_req, // one-cycle debug trap request
  output logic trap_set_tt, // write trap type into the base register
  output logic [7:0] trap_tt, // trap type of the debug trap
  output logic [31:0] trap_vector, // fixed entry address
  output logic [1:0] trap_level, // trap priority level
  output logic restore_req, // one-cycle write-back of saved bits
  output logic restore_ps, // previous-supervisor to restore
  output logic restore_et, // trap enable to restore
  output logic break_active_out // high while the break routine runs
);
  logic en_sync;
  logic ext_sync_n;
  logic debug_mode_n;
  logic debug_on;
  logic [31:0] ctl;
  logic in_break_routine;
  logic [29:0] instr_break_addr [2];
  logic [1:0] priv_sel;
  logic [1:0] addr_en;
  logic [1:0] pc_match;
  logic [1:0] addr_match_flag;
  logic saved_prev_supervisor;
  logic saved_trap_enable;
  logic ext_break_seen;
  logic ext_low;
  logic hw_gate;
  logic ext_hit;
  logic addr_hit;
  logic step_hit;
  logic sw_hit;
  logic next_trap;
  logic next_sw;
  logic trace_we;
  logic [29:0] trace_rd;
  logic [3:0] trace_newest_ptr;
  logic wr_strobe;
  logic rd_strobe;
  logic trace_sel;
  logic [31:0] next_rdata;

  // true when an access of this space hits the given register word
  function automatic logic reg_hit(input logic [31:0] a, input logic [31:0] ofs);
    return a[31:2] == ofs[31:2];
  endfunction

  // enable pin and external break both pass two flops first
  cdbu_sync u_en_sync
  (
    .ref_clk(ref_clk),
    .pin_in(debug_enable_n_pin),
    .pin_sync(en_sync)
  );

  cdbu_sync u_ext_sync
  (
    .ref_clk(ref_clk),
    .pin_in(external_break_n),
    .pin_sync(ext_sync_n)
  );

  // mode caught while reset is held, so the level at release stays
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      debug_mode_n <= en_sync;
  end

  assign debug_on = ~debug_mode_n;
  assign wr_strobe = reg_en & reg_wr & (reg_asi == cdbu_pkg::DBG_ASI);
  assign rd_strobe = reg_en & ~reg_wr & (reg_asi == cdbu_pkg::DBG_ASI);
  assign trace_sel = reg_addr[31:6] == cdbu_pkg::OFS_TRACE_LO[31:6];

  // control word; the in-break bit is kept on its own
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ctl <= cdbu_pkg::CONTROL_RESET & cdbu_pkg::CONTROL_WR_MASK;
    else if (wr_strobe && reg_hit(reg_addr, cdbu_pkg::OFS_CONTROL))
      ctl <= reg_wdata & cdbu_pkg::CONTROL_WR_MASK;
  end

  assign priv_sel = {ctl[cdbu_pkg::CTL_PRIV_2], ctl[cdbu_pkg::CTL_PRIV_1]};
  assign addr_en = {ctl[cdbu_pkg::CTL_EN_2], ctl[cdbu_pkg::CTL_EN_1]};

  // comparators: address register, pc compare and match flag per channel
  for (genvar k = 0; k < 2; k++)
  begin : g_cmp
    localparam logic [31:0] OFS = (k == 0) ? cdbu_pkg::OFS_BREAK_ADDR_1
                                           : cdbu_pkg::OFS_BREAK_ADDR_2;
    localparam int FLAG_BIT = (k == 0) ? cdbu_pkg::ST_MATCH_1 : cdbu_pkg::ST_MATCH_2;

    always_ff @(posedge ref_clk)
    begin
      if (reset)
        instr_break_addr[k] <= cdbu_pkg::BREAK_ADDR_RESET[31:2];
      else if (wr_strobe && reg_hit(reg_addr, OFS))
        instr_break_addr[k] <= reg_wdata[31:2];
    end

    // pc bits 31:2, privilege and enable must all agree
    assign pc_match[k] = debug_on & pc_valid & addr_en[k]
                         & (pc_exec[31:2] == instr_break_addr[k])
                         & (priv_sel[k] == psr_s);

    // a match that traps sets the flag, and the set beats a write
    always_ff @(posedge ref_clk)
    begin
      if (reset)
        addr_match_flag[k] <= 1'b0;
      else if (pc_match[k] && !in_break_routine && hw_gate)
        addr_match_flag[k] <= 1'b1;
      else if (wr_strobe && reg_hit(reg_addr, cdbu_pkg::OFS_STATUS))
        addr_match_flag[k] <= reg_wdata[FLAG_BIT];
    end
  end

  // break sources; hardware and external ones need traps on or the override
  assign ext_low = ~ext_sync_n;
  assign hw_gate = psr_et | ctl[cdbu_pkg::CTL_TRAPS_OFF];
  assign ext_hit = debug_on & ext_low & ~in_break_routine & hw_gate;
  assign addr_hit = (|pc_match) & ~in_break_routine & hw_gate;
  assign step_hit = debug_on & ctl[cdbu_pkg::CTL_STEP] & instr_done
                    & ~in_break_routine & hw_gate;
  assign sw_hit = debug_on & sw_break_instr & ~in_break_routine;
  assign next_trap = (ext_hit | addr_hit | step_hit | sw_hit) & ~trap_req;
  assign next_sw = sw_hit & ~trap_req;

  // one-cycle trap request; type only written for software breaks
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      trap_req <= 1'b0;
      trap_set_tt <= 1'b0;
    end
    else
    begin
      trap_req <= next_trap;
      trap_set_tt <= next_sw;
    end
  end

  assign trap_tt = cdbu_pkg::TRAP_TYPE;
  assign trap_vector = cdbu_pkg::TRAP_VECTOR;
  assign trap_level = cdbu_pkg::TRAP_LEVEL;

  // in-break bit: entry sets, return clears, software may also write it
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      in_break_routine <= 1'b0;
    else if (next_trap)
      in_break_routine <= 1'b1;
    else if (rett_exec && in_break_routine)
      in_break_routine <= 1'b0;
    else if (wr_strobe && reg_hit(reg_addr, cdbu_pkg::OFS_CONTROL))
      in_break_routine <= reg_wdata[cdbu_pkg::CTL_IN_BREAK];
  end

  assign break_active_out = in_break_routine;

  // saved state bits, read only to software
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      saved_prev_supervisor <= 1'b0;
      saved_trap_enable <= 1'b0;
    end
    else if (next_trap)
    begin
      saved_prev_supervisor <= psr_ps;
      saved_trap_enable <= psr_et;
    end
  end

  // write-back pulse on return from the break routine
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      restore_req <= 1'b0;
    else
      restore_req <= rett_exec & in_break_routine;
  end

  assign restore_ps = saved_prev_supervisor;
  assign restore_et = saved_trap_enable;

  // external break flag: set wins over a clearing write of zero
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ext_break_seen <= 1'b0;
    else if (debug_on && ext_low && !in_break_routine)
      ext_break_seen <= 1'b1;
    else if (wr_strobe && reg_hit(reg_addr, cdbu_pkg::OFS_STATUS)
             && !reg_wdata[cdbu_pkg::ST_EXT_SEEN])
      ext_break_seen <= 1'b0;
  end

  // trace records fetches in debug mode except while the break routine runs
  assign trace_we = debug_on & fetch_valid & ~in_break_routine;

  cdbu_trace u_trace
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .wr_en(trace_we),
    .wr_addr(fetch_addr[31:2]),
    .rd_index(reg_addr[5:2]),
    .rd_addr(trace_rd),
    .newest(trace_newest_ptr)
  );

  // read multiplexer; unmapped words read as zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    if (reg_hit(reg_addr, cdbu_pkg::OFS_BREAK_ADDR_1))
      next_rdata = {instr_break_addr[0], 2'b00};
    else if (reg_hit(reg_addr, cdbu_pkg::OFS_BREAK_ADDR_2))
      next_rdata = {instr_break_addr[1], 2'b00};
    else if (reg_hit(reg_addr, cdbu_pkg::OFS_CONTROL))
    begin
      next_rdata = ctl;
      next_rdata[cdbu_pkg::CTL_IN_BREAK] = in_break_routine;
    end
    else if (reg_hit(reg_addr, cdbu_pkg::OFS_STATUS))
    begin
      next_rdata[cdbu_pkg::ST_PTR_LSB +: 4] = trace_newest_ptr;
      next_rdata[cdbu_pkg::ST_SAVED_PS] = saved_prev_supervisor;
      next_rdata[cdbu_pkg::ST_SAVED_ET] = saved_trap_enable;
      next_rdata[cdbu_pkg::ST_EXT_SEEN] = ext_break_seen;
      next_rdata[cdbu_pkg::ST_MATCH_1] = addr_match_flag[0];
      next_rdata[cdbu_pkg::ST_MATCH_2] = addr_match_flag[1];
      next_rdata[cdbu_pkg::ST_MODE_N] = debug_mode_n;
    end
    else if (trace_sel)
      next_rdata = {trace_rd, 2'b00};
  end

  // read data registered; holds until the next read
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reg_rdata <= 32'h00000000;
    else if (rd_strobe)
      reg_rdata <= next_rdata;
  end

  // checks of the trap behaviour
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_normal_quiet: assert property (debug_mode_n |-> !trap_req && !trace_we)
    else $error("trap or trace activity in normal mode");

  a_mode_fixed: assert property (##1 $stable(debug_mode_n))
    else $error("sampled mode changed outside reset");

  a_vector_fixed: assert property (trap_req |-> trap_vector == 32'h00000ff0
                                   && trap_tt == 8'hff && trap_level == 2'h2)
    else $error("debug trap vector, type or level wrong");

  a_entry_active: assert property (next_trap |=> trap_req && break_active_out)
    else $error("trap entry without break-active");

  a_no_nesting: assert property ($past(break_active_out) |-> !trap_req)
    else $error("debug trap taken inside the break routine");

  a_return_clears: assert property (rett_exec && break_active_out
                                    |=> !break_active_out && restore_req)
    else $error("return did not end the break routine");

  a_saved_bits: assert property (next_trap ##1 !next_trap [*2]
                                 |-> restore_ps == $past(psr_ps, 2)
                                 && restore_et == $past(psr_et, 2))
    else $error("saved state bits lost after entry");

  a_traps_off: assert property (!psr_et && !ctl[cdbu_pkg::CTL_TRAPS_OFF]
                                && !sw_break_instr |=> !trap_req)
    else $error("hardware break taken with traps off");

  a_soft_break: assert property (debug_on && sw_break_instr && !break_active_out
                                 && !trap_req |=> trap_req && trap_set_tt)
    else $error("software break not raised");

  a_single_step: assert property (debug_on && ctl[cdbu_pkg::CTL_STEP] && instr_done
                                  && psr_et && !break_active_out && !trap_req
                                  && !sw_break_instr |=> trap_req && !trap_set_tt)
    else $error("single step trap missing");

  a_ext_break: assert property ((debug_on && !external_break_n && !break_active_out
                                && psr_et) [*2] |-> ##[1:2] (trap_req || break_active_out))
    else $error("external break not raised");

  a_ext_flag: assert property (debug_on && ext_low && !in_break_routine
                               |=> ext_break_seen)
    else $error("external break flag not set");

  a_flag_clear: assert property (wr_strobe && reg_hit(reg_addr, cdbu_pkg::OFS_STATUS)
                                 && !reg_wdata[cdbu_pkg::ST_EXT_SEEN]
                                 && !(debug_on && ext_low && !in_break_routine)
                                 |=> !ext_break_seen)
    else $error("external break flag not cleared by a write of zero");

  a_match_set: assert property (pc_match[0] && !in_break_routine && hw_gate
                                |=> addr_match_flag[0])
    else $error("match flag 1 not set by a trapping hit");

  a_trace_ptr: assert property (trace_we |=> trace_newest_ptr
                                == $past(trace_newest_ptr) + 4'h1)
    else $error("trace pointer did not advance");

  // one cover per break source, plus the trace pointer wrapping
  c_soft_entry: cover property (trap_req && trap_set_tt ##[1:20] restore_req);
  c_step_entry: cover property (trap_req && !trap_set_tt && ctl[cdbu_pkg::CTL_STEP]);
  c_ext_entry: cover property (ext_break_seen && trap_req);
  c_addr_entry: cover property (|addr_match_flag && trap_req);
  c_trace_wrap: cover property (trace_newest_ptr == 4'hf && trace_we ##1 trace_newest_ptr == 4'h0);
endmodule

//--- verification/cdbu_debugger.sv
// cdbu_debugger: model of the debug pod driving the enable and break pins
// assumes: commands from the bench change at the falling edge of ref_clk
`timescale 1ns/10ps
module cdbu_debugger
(
  input wire logic ref_clk, // core clock
  input wire logic want_debug, // select debug mode at reset
  input wire logic break_go, // start one break request
  input wire logic [7:0] break_len, // low time in clocks
  output logic debug_enable_n_pin, // low selects debug mode
  output logic external_break_n // low requests a break
);
  logic [7:0] low_left = 8'h00;
  // enable level only changes deep inside reset, far from its release
  assign debug_enable_n_pin = ~want_debug;
  // break pin held low for the commanded time, never under two clocks
  always_ff @(posedge ref_clk)
  begin
    if (break_go)
      low_left <= (break_len < 8'h02) ? 8'h02 : break_len;
    else if (low_left != 8'h00)
      low_left <= low_left - 8'h01;
  end
  // pulled up when the pod lets go
  assign external_break_n = (low_left == 8'h00);
endmodule

//--- verification/tb_cpu_debug_break_unit.sv
// tb_cpu_debug_break_unit: self-checking bench of the debug break unit
// assumes: the core side and register port are driven here at the falling edge
`timescale 1ns/10ps
module tb_cpu_debug_break_unit;
  logic ref_clk, reset, want_debug, break_go, debug_enable_n_pin, external_break_n;
  logic [7:0] break_len, reg_asi, trap_tt;
  logic reg_en, reg_wr, pc_valid, instr_done, sw_break_instr, rett_exec;
  logic psr_s, psr_ps, psr_et, fetch_valid, trap_req, trap_set_tt, restore_req;
  logic restore_ps, restore_et, break_active_out, last_tt;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, pc_exec, fetch_addr, trap_vector, q;
  logic [1:0] trap_level;
  int miscompares = 0;
  int checks_done = 0;
  int trap_count = 0;
  int restore_count = 0;

  cdbu_unit cdbu_unit_i (.ref_clk, .reset, .debug_enable_n_pin, .external_break_n, .reg_en,
    .reg_wr, .reg_asi, .reg_addr, .reg_wdata, .reg_rdata, .pc_valid, .pc_exec, .instr_done,
    .sw_break_instr, .rett_exec, .psr_s, .psr_ps, .psr_et, .fetch_valid, .fetch_addr,
    .trap_req, .trap_set_tt, .trap_tt, .trap_vector, .trap_level, .restore_req, .restore_ps,
    .restore_et, .break_active_out);
  cdbu_debugger cdbu_debugger_i (.ref_clk, .want_debug, .break_go, .break_len,
    .debug_enable_n_pin, .external_break_n);

  // clock generator
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // count trap and restore pulses
  always @(posedge ref_clk)
  begin
    if (trap_req === 1'b1)
    begin
      trap_count++;
      last_tt = trap_set_tt;
    end
    if (restore_req === 1'b1)
      restore_count++;
  end

  task automatic test_done;
  begin
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
  begin
    checks_done++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  end
  endtask

  task automatic chkb(input string what, input logic exp, input logic got);
  begin
    chk(what, {31'h0, exp}, {31'h0, got});
  end
  endtask

  // one register access, read data taken a cycle later
  task automatic acc(input logic [7:0] asi, input logic wr, input logic [31:0] a,
    input logic [31:0] d);
  begin
    reg_en = 1'b1;
    reg_wr = wr;
    reg_asi = asi;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_en = 1'b0;
    @(negedge ref_clk);
    q = reg_rdata;
  end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
  begin
    acc(8'h01, 1'b1, a, d);
  end
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
  begin
    acc(8'h01, 1'b0, a, 32'h0);
    chk(what, exp, q);
  end
  endtask

  // wait out a trap window, count pulses and check the fixed trap outputs
  task automatic traps(input int n);
  begin
    repeat (6) @(negedge ref_clk);
    chk("traps", n, trap_count);
    chk("tt", 32'hff, {24'h0, trap_tt});
    chk("vector", 32'h00000ff0, trap_vector);
    chk("level", 32'h2, {30'h0, trap_level});
    trap_count = 0;
  end
  endtask

  task automatic do_rett(input logic ps, input logic et);
  begin
    rett_exec = 1'b1;
    @(negedge ref_clk);
    rett_exec = 1'b0;
    repeat (2) @(negedge ref_clk);
    chkb("active", 1'b0, break_active_out);
    chk("restores", 1, restore_count);
    chkb("rst_ps", ps, restore_ps);
    chkb("rst_et", et, restore_et);
    restore_count = 0;
  end
  endtask

  task automatic do_reset(input logic dbg, input logic boot_brk);
  begin
    reset = 1'b1;
    want_debug = dbg;
    repeat (15) @(negedge ref_clk);
    break_len = 8'h0a;
    break_go = boot_brk;
    @(negedge ref_clk);
    break_go = 1'b0;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    trap_count = 0;
  end
  endtask

  // break held across reset release enters the routine at once
  task automatic t_boot;
  begin
    do_reset(1'b1, 1'b1);
    traps(1);
    chkb("active", 1'b1, break_active_out);
    wr(32'h0000ff1c, 32'h0);
    do_rett(1'b0, 1'b0);
    traps(0);
  end
  endtask

  // software break taken with traps off and the gate bit clear
  task automatic t_sw;
  begin
    wr(32'h0000ff18, 32'h0);
    psr_ps = 1'b1;
    sw_break_instr = 1'b1;
    @(negedge ref_clk);
    sw_break_instr = 1'b0;
    traps(1);
    chkb("set_tt", 1'b1, last_tt);
    rdchk("control", 32'h0000ff18, 32'h00000200);
    rdchk("status", 32'h0000ff1c, 32'h0000f200);
    do_rett(1'b1, 1'b0);
  end
  endtask

  // comparators: gate closed, privilege mismatch, then a hit
  task automatic t_cmp;
  begin
    psr_s = 1'b1;
    wr(32'h0000ff00, 32'h00001007);
    rdchk("addr1", 32'h0000ff00, 32'h00001004);
    wr(32'h0000ff04, 32'h00002000);
    wr(32'h0000ff18, 32'h00004060);
    pc_valid = 1'b1;
    pc_exec = 32'h00001004;
    @(negedge ref_clk);
    psr_et = 1'b1;
    pc_exec = 32'h00002000;
    @(negedge ref_clk);
    pc_exec = 32'h00001004;
    @(negedge ref_clk);
    pc_valid = 1'b0;
    traps(1);
    chkb("set_tt", 1'b0, last_tt);
    acc(8'h01, 1'b0, 32'h0000ff1c, 32'h0);
    chk("match", 32'h2, {30'h0, q[3:2]});
    do_rett(1'b1, 1'b1);
    wr(32'h0000ff1c, 32'h0000000c);
    acc(8'h01, 1'b0, 32'h0000ff1c, 32'h0);
    chk("match_wr", 32'h3, {30'h0, q[3:2]});
    wr(32'h0000ff1c, 32'h0);
  end
  endtask

  // trace of back-to-back fetches, then a single step
  task automatic t_step;
  begin
    fetch_valid = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      fetch_addr = 32'h00000100 + 32'h4 * i;
      @(negedge ref_clk);
    end
    fetch_valid = 1'b0;
    acc(8'h01, 1'b0, 32'h0000ff1c, 32'h0);
    chk("ptr", 32'h2, {28'h0, q[15:12]});
    rdchk("trace2", 32'h0000ff48, 32'h00000108);
    rdchk("trace0", 32'h0000ff40, 32'h00000100);
    wr(32'h0000ff18, 32'h00000410);
    instr_done = 1'b1;
    @(negedge ref_clk);
    instr_done = 1'b0;
    traps(1);
    do_rett(1'b1, 1'b1);
  end
  endtask

  // shortest legal external break, seen only after the synchroniser
  task automatic t_ext;
  begin
    wr(32'h0000ff18, 32'h00000400);
    break_len = 8'h02;
    break_go = 1'b1;
    @(negedge ref_clk);
    break_go = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("early", 0, trap_count);
    traps(1);
    acc(8'h01, 1'b0, 32'h0000ff1c, 32'h0);
    chkb("ext_seen", 1'b1, q[6]);
    wr(32'h0000ff1c, 32'h0);
    acc(8'h01, 1'b0, 32'h0000ff1c, 32'h0);
    chkb("ext_clr", 1'b0, q[6]);
    do_rett(1'b1, 1'b1);
  end
  endtask

  // normal mode: reset values, refused accesses, software and external breaks ignored
  task automatic t_normal;
  begin
    do_reset(1'b0, 1'b0);
    acc(8'h01, 1'b0, 32'h0000ff1c, 32'h0);
    chkb("mode_n", 1'b1, q[1]);
    rdchk("ctl_rst", 32'h0000ff18, 32'h00000400);
    rdchk("addr1_rst", 32'h0000ff00, 32'h0);
    rdchk("addr2_rst", 32'h0000ff04, 32'h0);
    acc(8'h02, 1'b1, 32'h0000ff18, 32'h0000ffff);
    rdchk("ctl_asi", 32'h0000ff18, 32'h00000400);
    rdchk("unmapped", 32'h0000ff08, 32'h0);
    sw_break_instr = 1'b1;
    break_go = 1'b1;
    @(negedge ref_clk);
    sw_break_instr = 1'b0;
    break_go = 1'b0;
    traps(0);
    chkb("active", 1'b0, break_active_out);
  end
  endtask

  // watchdog
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end

  // main sequence
  initial
  begin
    reset = 1'b1;
    want_debug = 1'b1;
    break_go = 1'b0;
    break_len = 8'h02;
    reg_en = 1'b0;
    reg_wr = 1'b0;
    reg_asi = 8'h01;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    pc_valid = 1'b0;
    pc_exec = 32'h0;
    instr_done = 1'b0;
    sw_break_instr = 1'b0;
    rett_exec = 1'b0;
    psr_s = 1'b0;
    psr_ps = 1'b0;
    psr_et = 1'b0;
    fetch_valid = 1'b0;
    fetch_addr = 32'h0;
    @(negedge ref_clk);
    t_boot();
    t_sw();
    t_cmp();
    t_step();
    t_ext();
    t_normal();
    test_done();
  end
endmodule
